// [rtl/aeis_pkg.sv]
// Constants and carrier types for the per-axis error and interrupt-cause status bank
package aeis_pkg;
  localparam int NAXIS = 4;
  localparam logic [3:0] ADDR_ERR_HOME = 4'h0;
  localparam logic [3:0] ADDR_CAUSE = 4'h1;
  localparam logic [3:0] ADDR_CAUSE_LO = 4'h2;
  localparam logic [3:0] ADDR_CAUSE_HI = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
  localparam logic [3:0] ADDR_CFG = 4'h5;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] ERR_MASK = 16'h1FBF;
  localparam logic [9:0] IEN_RST = 10'h000;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam int CFG_SLP_EN = 0;
  localparam int CFG_SLM_EN = 1;
  localparam int CFG_ALM_EN = 2;
  localparam int CFG_PULSE_POS = 3;

  // Per-axis drive-side events and levels
  typedef struct packed {
    logic drv_plus;
    logic drv_minus;
    logic drive_end;
    logic pulse;
    logic [31:0] pos;
    logic [31:0] comp_hi;
    logic [31:0] comp_lo;
    logic accdec;
    logic const_zone;
    logic home_done;
    logic home_err;
    logic [4:0] home_step;
    logic sync_start;
    logic lim_plus_act;
    logic lim_minus_act;
    logic alarm_act;
  } aeis_axis_in_t;

  typedef enum logic [1:0] {
    AEIS_IDLE = 2'b00,
    AEIS_RUN_P = 2'b01,
    AEIS_RUN_M = 2'b10
  } aeis_drv_t;
endpackage : aeis_pkg

// [rtl/aeis_bank.sv]
// Per-axis error/home status and interrupt-cause registers with interrupt output
`timescale 1ns/100ps
module aeis_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [1:0] axis_sel,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Drive side
  input aeis_pkg::aeis_axis_in_t ax_in [aeis_pkg::NAXIS],
  input wire logic [3:0] drive_req_plus,
  input wire logic [3:0] drive_req_minus,
  input wire logic emg_n,
  output logic [3:0] drive_grant,
  output logic [3:0] stop_req,
  output logic [3:0] err_summary,
  output logic irq_n
);
  logic [15:0] err_reg [aeis_pkg::NAXIS];
  logic [9:0] cause [aeis_pkg::NAXIS];
  logic [9:0] ien [aeis_pkg::NAXIS];
  logic [3:0] cfg [aeis_pkg::NAXIS];
  logic [3:0] blk_p;
  logic [3:0] blk_m;
  logic [3:0] ge_lo_q;
  logic [3:0] gt_hi_q;
  logic [3:0] cz_q;
  logic [3:0] lt_hi_q;
  logic irq_any;
  logic [9:0] ev [aeis_pkg::NAXIS];
  logic [15:0] next_err [aeis_pkg::NAXIS];
  logic [3:0] clr_hit;

  // Signed greater-than used by several compare checks
  function automatic logic sgt(input logic [31:0] a, input logic [31:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction : sgt

  // Next cause word; a fresh event wins over a read clear in the same cycle
  function automatic logic [9:0] merge_cause(input logic clr, input logic [9:0] cur,
                                             input logic [9:0] evt);
    merge_cause = (clr ? 10'h000 : cur) | evt;
  endfunction : merge_cause

  // Error word and cause events, combinational per axis
  always_comb begin
    for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
      next_err[i] = aeis_pkg::RST_WORD;
      next_err[i][0] = cfg[i][aeis_pkg::CFG_SLP_EN] && ax_in[i].drv_plus
                       && sgt(ax_in[i].pos, ax_in[i].comp_hi);
      next_err[i][1] = cfg[i][aeis_pkg::CFG_SLM_EN] && ax_in[i].drv_minus
                       && sgt(ax_in[i].comp_lo, ax_in[i].pos);
      next_err[i][2] = ax_in[i].lim_plus_act;
      next_err[i][3] = ax_in[i].lim_minus_act;
      next_err[i][4] = cfg[i][aeis_pkg::CFG_ALM_EN] && ax_in[i].alarm_act;
      next_err[i][5] = !emg_n;
      next_err[i][7] = ax_in[i].home_err;
      next_err[i][12:8] = ax_in[i].home_step;
      next_err[i] = next_err[i] & aeis_pkg::ERR_MASK;
      ev[i] = '0;
      ev[i][0] = ax_in[i].pulse && cfg[i][aeis_pkg::CFG_PULSE_POS];
      ev[i][1] = !ge_lo_q[i] && !sgt(ax_in[i].comp_lo, ax_in[i].pos);
      ev[i][2] = ge_lo_q[i] && sgt(ax_in[i].comp_lo, ax_in[i].pos);
      ev[i][3] = !lt_hi_q[i] && sgt(ax_in[i].comp_hi, ax_in[i].pos);
      ev[i][4] = !gt_hi_q[i] && sgt(ax_in[i].pos, ax_in[i].comp_hi);
      ev[i][5] = ax_in[i].accdec && cz_q[i] && !ax_in[i].const_zone;
      ev[i][6] = ax_in[i].accdec && !cz_q[i] && ax_in[i].const_zone;
      ev[i][7] = ax_in[i].drive_end;
      ev[i][8] = ax_in[i].home_done;
      ev[i][9] = ax_in[i].sync_start;
      ev[i] = ev[i] & ien[i];
    end
  end

  // Read clear: word read, or low-byte read clears both bytes
  always_comb begin
    clr_hit = '0;
    if (rd && (addr == aeis_pkg::ADDR_CAUSE || addr == aeis_pkg::ADDR_CAUSE_LO)) begin
      clr_hit[axis_sel] = 1'b1;
    end
  end

  // Compare history for crossing detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ge_lo_q <= '0;
      gt_hi_q <= '0;
      lt_hi_q <= '0;
      cz_q <= '0;
    end else begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        ge_lo_q[i] <= !sgt(ax_in[i].comp_lo, ax_in[i].pos);
        gt_hi_q[i] <= sgt(ax_in[i].pos, ax_in[i].comp_hi);
        lt_hi_q[i] <= sgt(ax_in[i].comp_hi, ax_in[i].pos); // Own history, so equal is not lost
        cz_q[i] <= ax_in[i].const_zone;
      end
    end
  end

  // Status registers, one set per axis
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        err_reg[i] <= aeis_pkg::RST_WORD;
      end
    end else begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        err_reg[i] <= next_err[i];
      end
    end
  end

  // Cause bits: a new event wins over a read clear in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        cause[i] <= '0;
      end
    end else begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        cause[i] <= merge_cause(clr_hit[i], cause[i], ev[i]);
      end
    end
  end

  // Software writable enables and configuration
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        ien[i] <= aeis_pkg::IEN_RST;
        cfg[i] <= aeis_pkg::CFG_RST;
      end
    end else if (wr) begin
      if (addr == aeis_pkg::ADDR_IRQ_EN) ien[axis_sel] <= wdata[9:0];
      if (addr == aeis_pkg::ADDR_CFG) cfg[axis_sel] <= wdata[3:0];
    end
  end

  // Limit stop and same-direction lockout; unlocks on a drive the other way
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      blk_p <= '0;
      blk_m <= '0;
      stop_req <= '0;
      drive_grant <= '0;
    end else begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        stop_req[i] <= (ax_in[i].drv_plus && (next_err[i][0] || next_err[i][2]))
                    || (ax_in[i].drv_minus && (next_err[i][1] || next_err[i][3]));
        if (ax_in[i].drv_plus && (next_err[i][0] || next_err[i][2])) blk_p[i] <= 1'b1;
        else if (drive_req_minus[i]) blk_p[i] <= 1'b0;
        if (ax_in[i].drv_minus && (next_err[i][1] || next_err[i][3])) blk_m[i] <= 1'b1;
        else if (drive_req_plus[i]) blk_m[i] <= 1'b0;
        drive_grant[i] <= (drive_req_plus[i] && !blk_p[i])
                       || (drive_req_minus[i] && !blk_m[i]);
      end
    end
  end

  // Any pending or arriving cause on any axis keeps the pin asserted
  always_comb begin
    irq_any = 1'b0;
    for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
      irq_any = irq_any || (|merge_cause(clr_hit[i], cause[i], ev[i]));
    end
  end

  // Summary and interrupt outputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      err_summary <= '0;
      irq_n <= 1'b1;
    end else begin
      for (int i = 0; i < aeis_pkg::NAXIS; i++) begin
        err_summary[i] <= |next_err[i][7:0];
      end
      irq_n <= !irq_any;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= aeis_pkg::RST_WORD;
    end else if (rd) begin
      case (addr)
        aeis_pkg::ADDR_ERR_HOME: rdata <= err_reg[axis_sel];
        aeis_pkg::ADDR_CAUSE: rdata <= {6'h00, cause[axis_sel]};
        aeis_pkg::ADDR_CAUSE_LO: rdata <= {8'h00, cause[axis_sel][7:0]};
        aeis_pkg::ADDR_CAUSE_HI: rdata <= {14'h0000, cause[axis_sel][9:8]};
        aeis_pkg::ADDR_IRQ_EN: rdata <= {6'h00, ien[axis_sel]};
        aeis_pkg::ADDR_CFG: rdata <= {12'h000, cfg[axis_sel]};
        default: rdata <= aeis_pkg::RST_WORD;
      endcase
    end else begin
      rdata <= aeis_pkg::RST_WORD;
    end
  end

  // Per-axis checks; one copy of the set runs on every axis
  for (genvar g = 0; g < aeis_pkg::NAXIS; g++) begin : g_axis_chk
    // Summary follows the error byte with the same one-cycle lag
    chk_err_summary: assert property (@(posedge mclk) disable iff (!rstn)
      1'b1 |=> err_summary[g] == |$past(next_err[g][7:0]))
      else $error("summary mismatch");
    // Unused positions must never leak a value
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
      (err_reg[g][15:13] == 3'h0) && !err_reg[g][6])
      else $error("reserved bits set");
    // Home search step is shown as given
    chk_home_step: assert property (@(posedge mclk) disable iff (!rstn)
      1'b1 |=> err_reg[g][12:8] == $past(ax_in[g].home_step))
      else $error("home step mismatch");
    // Plus soft limit past the upper compare
    chk_soft_plus: assert property (@(posedge mclk) disable iff (!rstn)
      cfg[g][aeis_pkg::CFG_SLP_EN] && ax_in[g].drv_plus
      && sgt(ax_in[g].pos, ax_in[g].comp_hi) |=> err_reg[g][0])
      else $error("soft plus missing");
    // Minus soft limit below the lower compare
    chk_soft_minus: assert property (@(posedge mclk) disable iff (!rstn)
      cfg[g][aeis_pkg::CFG_SLM_EN] && ax_in[g].drv_minus
      && sgt(ax_in[g].comp_lo, ax_in[g].pos) |=> err_reg[g][1])
      else $error("soft minus missing");
    // No plus soft limit unless driving plus
    chk_soft_rev: assert property (@(posedge mclk) disable iff (!rstn)
      !ax_in[g].drv_plus |=> !err_reg[g][0])
      else $error("soft limit in reverse");
    // No minus soft limit unless driving minus
    chk_soft_rev_minus: assert property (@(posedge mclk) disable iff (!rstn)
      !ax_in[g].drv_minus |=> !err_reg[g][1])
      else $error("soft minus in reverse");
    // Hardware limits are shown as levels
    chk_hard_plus: assert property (@(posedge mclk) disable iff (!rstn)
      ax_in[g].lim_plus_act |=> err_reg[g][2])
      else $error("hard limit missing");
    // Minus hardware limit level
    chk_hard_minus: assert property (@(posedge mclk) disable iff (!rstn)
      ax_in[g].lim_minus_act |=> err_reg[g][3])
      else $error("hard minus missing");
    // Alarm shows only once enabled
    chk_alarm_bit: assert property (@(posedge mclk) disable iff (!rstn)
      cfg[g][aeis_pkg::CFG_ALM_EN] && ax_in[g].alarm_act |=> err_reg[g][4])
      else $error("alarm missing");
    // A disabled alarm stays hidden
    chk_alarm_off: assert property (@(posedge mclk) disable iff (!rstn)
      !cfg[g][aeis_pkg::CFG_ALM_EN] |=> !err_reg[g][4])
      else $error("alarm while disabled");
    // Emergency stop is shared by all axes
    chk_emg_bit: assert property (@(posedge mclk) disable iff (!rstn)
      !emg_n |=> err_reg[g][5])
      else $error("emergency bit missing");
    // Home search error flag
    chk_home_error: assert property (@(posedge mclk) disable iff (!rstn)
      ax_in[g].home_err |=> err_reg[g][7])
      else $error("home error missing");
    // Plus limit stops the drive and blocks a plus-only restart
    chk_stop_limit: assert property (@(posedge mclk) disable iff (!rstn)
      ax_in[g].drv_plus && ax_in[g].lim_plus_act |=> stop_req[g] ##1
      !(drive_grant[g] && $past(drive_req_plus[g]) && !$past(drive_req_minus[g])))
      else $error("limit stop missing");
    // Minus limit stops the drive
    chk_stop_minus: assert property (@(posedge mclk) disable iff (!rstn)
      ax_in[g].drv_minus && ax_in[g].lim_minus_act |=> stop_req[g])
      else $error("minus stop missing");
    // Locked plus direction is never granted
    chk_lockout: assert property (@(posedge mclk) disable iff (!rstn)
      blk_p[g] && drive_req_plus[g] && !drive_req_minus[g] |=> !drive_grant[g])
      else $error("locked drive granted");
    // Locked minus direction is never granted
    chk_lockout_minus: assert property (@(posedge mclk) disable iff (!rstn)
      blk_m[g] && drive_req_minus[g] && !drive_req_plus[g] |=> !drive_grant[g])
      else $error("locked minus granted");
    // A clearing read with no new event empties the word
    chk_read_clears: assert property (@(posedge mclk) disable iff (!rstn)
      clr_hit[g] && ev[g] == 10'h000 |=> cause[g] == 10'h000)
      else $error("cause not cleared");
    // Drive end is recorded
    chk_event_sets: assert property (@(posedge mclk) disable iff (!rstn)
      ev[g][7] |=> cause[g][7])
      else $error("drive end lost");
    // Every event lands in its own bit
    chk_cause_sets: assert property (@(posedge mclk) disable iff (!rstn)
      ev[g] != 10'h000 |=> (cause[g] & $past(ev[g])) == $past(ev[g]))
      else $error("event lost");
    // Pulse cause with positive pulse logic
    chk_pulse_cause: assert property (@(posedge mclk) disable iff (!rstn)
      ax_in[g].pulse && cfg[g][aeis_pkg::CFG_PULSE_POS] && ien[g][0] |=> cause[g][0])
      else $error("pulse cause lost");
    // Count reaches the lower compare
    chk_ge_lo_cross: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g][1] && !ge_lo_q[g] && !sgt(ax_in[g].comp_lo, ax_in[g].pos) |=> cause[g][1])
      else $error("lower rise lost");
    // Count drops below the lower compare
    chk_lt_lo_cross: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g][2] && ge_lo_q[g] && sgt(ax_in[g].comp_lo, ax_in[g].pos) |=> cause[g][2])
      else $error("lower fall lost");
    // Count drops below the upper compare
    chk_lt_hi_cross: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g][3] && !lt_hi_q[g] && sgt(ax_in[g].comp_hi, ax_in[g].pos) |=> cause[g][3])
      else $error("upper fall lost");
    // Count rises above the upper compare
    chk_gt_hi_cross: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g][4] && !gt_hi_q[g] && sgt(ax_in[g].pos, ax_in[g].comp_hi) |=> cause[g][4])
      else $error("upper rise lost");
    // Constant zone start
    chk_const_start: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g][6] && ax_in[g].accdec && !cz_q[g] && ax_in[g].const_zone |=> cause[g][6])
      else $error("zone start lost");
    // Constant zone end
    chk_const_end: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g][5] && ax_in[g].accdec && cz_q[g] && !ax_in[g].const_zone |=> cause[g][5])
      else $error("zone end lost");
    // Home search end
    chk_home_cause: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g][8] && ax_in[g].home_done |=> cause[g][8])
      else $error("home end lost");
    // Pending cause holds the pin low
    chk_irq_low: assert property (@(posedge mclk) disable iff (!rstn)
      (cause[g] != 10'h000) && !clr_hit[g] |=> !irq_n)
      else $error("irq not asserted");
    // Masked causes raise nothing
    chk_masked_quiet: assert property (@(posedge mclk) disable iff (!rstn)
      ien[g] == 10'h000 |-> ev[g] == 10'h000)
      else $error("masked cause raised");
    // Error word read returns the selected axis
    chk_read_err: assert property (@(posedge mclk) disable iff (!rstn)
      rd && (addr == aeis_pkg::ADDR_ERR_HOME) && (axis_sel == g)
      |=> rdata == $past(err_reg[g]))
      else $error("error word read wrong");
    // Cause word read returns the selected axis
    chk_read_cause: assert property (@(posedge mclk) disable iff (!rstn)
      rd && (addr == aeis_pkg::ADDR_CAUSE) && (axis_sel == g)
      |=> rdata == {6'h00, $past(cause[g])})
      else $error("cause read wrong");
  end

  // Main scenarios: clear by read, limit stop, set against clear, high byte, lockout
  cov_clear_read: cover property (@(posedge mclk) disable iff (!rstn) clr_hit[0] && !irq_n);
  cov_limit_stop: cover property (@(posedge mclk) disable iff (!rstn) stop_req[1]);
  cov_set_and_clr: cover property (@(posedge mclk) clr_hit[0] && ev[0] != 10'h000);
  cov_high_byte: cover property (@(posedge mclk) rd && (addr == aeis_pkg::ADDR_CAUSE_HI));
  cov_lockout: cover property (@(posedge mclk) disable iff (!rstn) |blk_p);
endmodule : aeis_bank

// [bench/aeis_host.sv]
// Host bus master model for the status bank
`timescale 1ns/100ps
module aeis_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [1:0] axis_sel,
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  // Idle bus at time zero
  initial begin
    {axis_sel, addr, wdata, wr, rd} = '0;
  end
  // One-cycle write, launched just after an edge
  task automatic wr_reg(input logic [1:0] ax, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    axis_sel <= ax;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // One-cycle read; data is taken by the bench monitor
  task automatic rd_reg(input logic [1:0] ax, input logic [3:0] a);
    @(posedge mclk);
    axis_sel <= ax;
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask : rd_reg
  // Causes only reach the interrupt pin once enabled
  task automatic enable_all(input logic [1:0] ax);
    wr_reg(ax, aeis_pkg::ADDR_IRQ_EN, 16'h03FF);
  endtask : enable_all
endmodule : aeis_host

// [bench/tb.sv]
// Self-checking bench for the error and interrupt-cause status bank
`timescale 1ns/100ps
module tb;
  logic mclk, rstn, emg_n, wr, rd, rd_q, irq_n;
  logic [1:0] axis_sel;
  logic [3:0] addr, drive_req_plus, drive_req_minus, drive_grant, stop_req, err_summary;
  logic [15:0] wdata, rdata;
  logic [4:0] hs;
  aeis_pkg::aeis_axis_in_t ax_in [aeis_pkg::NAXIS];
  logic [15:0] exp_q[$];
  int fails, cmp_count, seed, a, s, i;
  int order [10] = '{0, 2, 1, 4, 3, 6, 5, 7, 8, 9};

  aeis_bank uut (.mclk(mclk), .rstn(rstn), .axis_sel(axis_sel), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ax_in(ax_in), .drive_req_plus(drive_req_plus),
    .drive_req_minus(drive_req_minus), .emg_n(emg_n), .drive_grant(drive_grant),
    .stop_req(stop_req), .err_summary(err_summary), .irq_n(irq_n));
  aeis_host host (.mclk(mclk), .axis_sel(axis_sel), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic exp_rd(input int ax, input logic [3:0] ad, input logic [15:0] v);
    exp_q.push_back(v);
    host.rd_reg(ax[1:0], ad);
  endtask : exp_rd

  // Read data stands only in the cycle after the strobe, so sample mid-cycle
  always @(posedge mclk) rd_q <= rd;
  always @(negedge mclk) begin
    if (rd_q) check("read data", rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // Bounded look for a grant pulse after a drive request
  task automatic req_grant(input int ax, input logic plus, input logic want);
    logic got;
    got = 1'b0;
    @(posedge mclk);
    if (plus) drive_req_plus[ax] <= 1'b1; else drive_req_minus[ax] <= 1'b1;
    @(posedge mclk);
    {drive_req_plus, drive_req_minus} <= '0;
    repeat (4) begin
      @(negedge mclk);
      if (drive_grant[ax] === 1'b1) got = 1'b1;
    end
    check("drive grant", {15'h0000, got}, {15'h0000, want});
  endtask : req_grant

  // One event per interrupt cause bit
  task automatic fire(input int b, input int ax);
    @(posedge mclk);
    case (b)
      0: ax_in[ax].pulse <= 1'b1;
      1, 3: ax_in[ax].pos <= 32'h0000_0000;
      2: ax_in[ax].pos <= 32'hFFFF_F830;
      4: ax_in[ax].pos <= 32'h0000_07D0;
      5: ax_in[ax].const_zone <= 1'b0;
      6: ax_in[ax].const_zone <= 1'b1;
      7: ax_in[ax].drive_end <= 1'b1;
      8: ax_in[ax].home_done <= 1'b1;
      default: ax_in[ax].sync_start <= 1'b1;
    endcase
    @(posedge mclk);
    {ax_in[ax].pulse, ax_in[ax].drive_end, ax_in[ax].home_done, ax_in[ax].sync_start} <= '0;
  endtask : fire

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    seed = 32'hc593;
    {rstn, drive_req_plus, drive_req_minus, fails, cmp_count} = '0;
    emg_n = 1'b1;
    for (i = 0; i < 4; i++) begin
      ax_in[i] = '0;
      ax_in[i].accdec = 1'b1;
      ax_in[i].comp_hi = 32'h0000_03E8;
      ax_in[i].comp_lo = 32'hFFFF_FC18;
    end
    cyc(20);
    rstn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      exp_rd(i, aeis_pkg::ADDR_ERR_HOME, 16'h0000);
      exp_rd(i, aeis_pkg::ADDR_CAUSE, 16'h0000);
    end
    exp_rd(0, 4'hF, 16'h0000);
    check("irq idle", {15'h0000, irq_n}, 16'h0001);
    $display("test reset done");
    a = $unsigned($random(seed)) % 4;
    hs = 5'($random(seed));
    host.wr_reg(a[1:0], aeis_pkg::ADDR_CFG, 16'h0004);
    @(posedge mclk);
    {ax_in[a].lim_plus_act, ax_in[a].lim_minus_act, ax_in[a].alarm_act} <= 3'h7;
    {ax_in[a].home_err, ax_in[a].home_step} <= {1'b1, hs};
    emg_n <= 1'b0;
    cyc(3);
    exp_rd(a, aeis_pkg::ADDR_ERR_HOME, {3'h0, hs, 8'hBC});
    exp_rd((a + 1) % 4, aeis_pkg::ADDR_ERR_HOME, 16'h0020);
    check("error summary", {12'h000, err_summary}, 16'h000F);
    {ax_in[a].lim_plus_act, ax_in[a].lim_minus_act, ax_in[a].alarm_act} <= 3'h0;
    {ax_in[a].home_err, ax_in[a].home_step, emg_n} <= 7'h01;
    cyc(3);
    exp_rd(a, aeis_pkg::ADDR_ERR_HOME, 16'h0000);
    check("error summary", {12'h000, err_summary}, 16'h0000);
    $display("test levels done");
    s = (a + 2) % 4;
    host.wr_reg(s[1:0], aeis_pkg::ADDR_CFG, 16'h0003);
    {ax_in[s].drv_plus, ax_in[s].pos} <= {1'b1, 32'h0000_03E9};
    cyc(3);
    exp_rd(s, aeis_pkg::ADDR_ERR_HOME, 16'h0001);
    check("limit stop", {15'h0000, stop_req[s]}, 16'h0001);
    req_grant(s, 1'b1, 1'b0);
    {ax_in[s].drv_plus, ax_in[s].drv_minus} <= 2'b01;
    cyc(3);
    exp_rd(s, aeis_pkg::ADDR_ERR_HOME, 16'h0000);
    ax_in[s].pos <= 32'hFFFF_FC17;
    cyc(3);
    exp_rd(s, aeis_pkg::ADDR_ERR_HOME, 16'h0002);
    {ax_in[s].drv_minus, ax_in[s].pos} <= '0;
    req_grant(s, 1'b0, 1'b0);
    req_grant(s, 1'b1, 1'b1);
    $display("test soft limits done");
    host.wr_reg(a[1:0], aeis_pkg::ADDR_CFG, 16'h0008);
    host.enable_all(a[1:0]);
    for (i = 0; i < 10; i++) begin
      fire(order[i], a);
      cyc(2);
      check("irq low", {15'h0000, irq_n}, 16'h0000);
      if (order[i] < 8) exp_rd(a, aeis_pkg::ADDR_CAUSE, 16'h0001 << order[i]);
      else begin
        exp_rd(a, aeis_pkg::ADDR_CAUSE_HI, 16'h0001 << (order[i] - 8));
        exp_rd(a, aeis_pkg::ADDR_CAUSE_LO, 16'h0000);
      end
      exp_rd(a, aeis_pkg::ADDR_CAUSE, 16'h0000);
      cyc(2);
      check("irq released", {15'h0000, irq_n}, 16'h0001);
    end
    $display("test interrupt causes done");
    wrap_up();
  end
endmodule : tb
